// ==== pkg/rtlsb_map.vh ====
// Register offsets, field widths and reset values of the link status bank.
`ifndef RTLSB_MAP_VH
`define RTLSB_MAP_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define RTLSB_ADDR_TXQ_COUNT 8'h8f
`define RTLSB_ADDR_VCO_CAL 8'h9a
`define RTLSB_ADDR_TX_INFO 8'h9c
`define RTLSB_ADDR_RX_INFO 8'h9d
`define RTLSB_ADDR_FREQ_CORR 8'h9e
`define RTLSB_ADDR_LQ_PREAMBLE 8'h9f
`define RTLSB_ADDR_LQ_SYNC 8'ha0
`define RTLSB_ADDR_CAPT_RSSI 8'ha2
`define RTLSB_ADDR_LEN_HIGH 8'ha4
`define RTLSB_ADDR_LEN_LOW 8'ha5
`define RTLSB_ADDR_CHECK3 8'ha6
`define RTLSB_ADDR_CHECK2 8'ha7
`define RTLSB_ADDR_CHECK1 8'ha8
`define RTLSB_ADDR_CHECK0 8'ha9
`define RTLSB_ADDR_SRC_ADDR 8'haa
`define RTLSB_ADDR_DST_ADDR 8'hab
`define RTLSB_ADDR_RUN_RSSI 8'hef
`define RTLSB_ADDR_PART_ID 8'hf0
`define RTLSB_ADDR_VERSION_ID 8'hf1
`define RTLSB_ADDR_IRQ3 8'hfa
`define RTLSB_ADDR_IRQ2 8'hfb
`define RTLSB_ADDR_IRQ1 8'hfc
`define RTLSB_ADDR_IRQ0 8'hfd

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RTLSB_RST_BYTE 8'h00
`define RTLSB_RST_IRQ 32'h0009_0500

// ----------------------------------------------------------------------------
// Widths of the captured fields
// ----------------------------------------------------------------------------
`define RTLSB_VCO_TH_W 127
`define RTLSB_SEQ_W 2
`define RTLSB_RETX_W 4
`define RTLSB_SYNC_Q_W 7
`define RTLSB_LEN_W 15

`endif

// ==== design/rtlsb_thermo_to_bin.v ====
// Thermometer to binary converter for the oscillator bank calibration word.
`timescale 1ns/1ps

module rtlsb_thermo_to_bin #(
    parameter TH_W = 127,
    parameter BIN_W = 7
) (
    // Thermometer code, ones filled from bit 0 upward.
    input wire [TH_W-1:0] thermo_i,
    // Binary count of ones.
    output reg [BIN_W-1:0] bin_o
);

    integer k;

    // Counting ones rather than finding the top one tolerates a bubble in the code.
    always @* begin
        bin_o = {BIN_W{1'b0}};
        for (k = 0; k < TH_W; k = k + 1) begin
            bin_o = bin_o + {{(BIN_W-1){1'b0}}, thermo_i[k]};
        end
    end

endmodule // rtlsb_thermo_to_bin

// ==== design/rtlsb_status_bank.v ====
// Read-only status register bank of the link: calibration, packet and interrupt state.
`timescale 1ns/1ps
`include "rtlsb_map.vh"

module rtlsb_status_bank #(
    parameter [7:0] PART_ID = 8'h5a,    // Arbitrary value.
    parameter [7:0] VERSION_ID = 8'ha5  // Arbitrary value.
) (
    // Clock and reset.
    input wire clock_i,
    input wire rst_n_i,
    // Register port from the serial interface.
    input wire [7:0] reg_addr_i,
    input wire reg_rd_i,
    input wire reg_wr_i,
    input wire [7:0] reg_wdata_i,
    output reg [7:0] reg_rdata_o,
    output reg reg_rvalid_o,
    // Oscillator calibration.
    input wire vco_cal_done_i,
    input wire [`RTLSB_VCO_TH_W-1:0] vco_cal_thermo_i,
    // Transmit side.
    input wire tx_start_i,
    input wire [`RTLSB_SEQ_W-1:0] transmit_sequence_number_i,
    input wire tx_retx_i,
    input wire [7:0] transmit_queue_count_i,
    // Receive side.
    input wire rx_sync_done_i,
    input wire rx_pkt_done_i,
    input wire received_no_ack_flag_i,
    input wire [`RTLSB_SEQ_W-1:0] received_sequence_number_i,
    input wire [7:0] preamble_quality_index_i,
    input wire [`RTLSB_SYNC_Q_W-1:0] sync_quality_index_i,
    input wire carrier_sense_i,
    input wire [7:0] signal_strength_i,
    input wire [`RTLSB_LEN_W-1:0] received_length_i,
    input wire [31:0] received_check_i,
    input wire [7:0] received_source_address_i,
    input wire [7:0] received_destination_address_i,
    input wire [7:0] freq_offset_correction_i,
    // Interrupt vector from the interrupt logic.
    input wire [31:0] irq_vector_i
);

    // ------------------------------------------------------------------------
    // Stored status
    // ------------------------------------------------------------------------
    wire [6:0] cal_bin;
    reg [6:0] osc_bank_cal_word;
    reg [`RTLSB_SEQ_W-1:0] tx_seq;
    reg [`RTLSB_RETX_W-1:0] retransmission_count;
    reg rx_no_ack;
    reg [`RTLSB_SEQ_W-1:0] rx_seq;
    reg [7:0] preamble_quality;
    reg [`RTLSB_SYNC_Q_W-1:0] sync_quality;
    reg carrier;
    reg [7:0] captured_signal_strength;
    reg [7:0] running_signal_strength;
    reg [`RTLSB_LEN_W-1:0] received_length;
    reg [31:0] rx_check;
    reg [7:0] rx_src;
    reg [7:0] rx_dst;
    reg [7:0] freq_corr;
    reg [7:0] txq_count;
    reg [31:0] irq_vector;
    reg [7:0] next_rdata;

    rtlsb_thermo_to_bin #(
        .TH_W(`RTLSB_VCO_TH_W),
        .BIN_W(7)
    ) u_cal_conv (
        .thermo_i(vco_cal_thermo_i),
        .bin_o(cal_bin)
    );

    // ------------------------------------------------------------------------
    // Capture of calibration and transmit state
    // ------------------------------------------------------------------------
    // Calibration result is taken when the calibrator reports done.
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            osc_bank_cal_word <= 7'h00;
            tx_seq <= 2'h0;
            retransmission_count <= 4'h0;
            txq_count <= `RTLSB_RST_BYTE;
        end else begin
            if (vco_cal_done_i) begin
                osc_bank_cal_word <= cal_bin;
            end
            txq_count <= transmit_queue_count_i;
            // A new packet restarts the count; a retry at the same edge still counts once.
            if (tx_start_i) begin
                tx_seq <= transmit_sequence_number_i;
                retransmission_count <= {3'h0, tx_retx_i};
            end else if (tx_retx_i && retransmission_count != 4'hf) begin
                retransmission_count <= retransmission_count + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Capture of receive state
    // ------------------------------------------------------------------------
    // Sync-time values freeze at sync detection; packet fields at packet end.
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_no_ack <= 1'b0;
            rx_seq <= 2'h0;
            preamble_quality <= `RTLSB_RST_BYTE;
            sync_quality <= 7'h00;
            carrier <= 1'b0;
            captured_signal_strength <= `RTLSB_RST_BYTE;
            running_signal_strength <= `RTLSB_RST_BYTE;
            received_length <= 15'h0000;
            rx_check <= 32'h0000_0000;
            rx_src <= `RTLSB_RST_BYTE;
            rx_dst <= `RTLSB_RST_BYTE;
            freq_corr <= `RTLSB_RST_BYTE;
            irq_vector <= `RTLSB_RST_IRQ;
        end else begin
            // Refreshed every cycle so repeated reads track the channel.
            running_signal_strength <= signal_strength_i;
            carrier <= carrier_sense_i;
            irq_vector <= irq_vector_i;
            freq_corr <= freq_offset_correction_i;
            if (rx_sync_done_i) begin
                captured_signal_strength <= signal_strength_i;
                preamble_quality <= preamble_quality_index_i;
                sync_quality <= sync_quality_index_i;
            end
            if (rx_pkt_done_i) begin
                rx_no_ack <= received_no_ack_flag_i;
                rx_seq <= received_sequence_number_i;
                received_length <= received_length_i;
                rx_check <= received_check_i;
                rx_src <= received_source_address_i;
                rx_dst <= received_destination_address_i;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------------------
    // Unmapped addresses read zero.
    always @* begin
        case (reg_addr_i)
            `RTLSB_ADDR_TXQ_COUNT: next_rdata = txq_count;
            `RTLSB_ADDR_VCO_CAL: next_rdata = {1'b0, osc_bank_cal_word};
            `RTLSB_ADDR_TX_INFO: next_rdata = {2'h0, tx_seq, retransmission_count};
            `RTLSB_ADDR_RX_INFO: next_rdata = {5'h00, rx_no_ack, rx_seq};
            `RTLSB_ADDR_FREQ_CORR: next_rdata = freq_corr;
            `RTLSB_ADDR_LQ_PREAMBLE: next_rdata = preamble_quality;
            `RTLSB_ADDR_LQ_SYNC: next_rdata = {carrier, sync_quality};
            `RTLSB_ADDR_CAPT_RSSI: next_rdata = captured_signal_strength;
            `RTLSB_ADDR_LEN_HIGH: next_rdata = {1'b0, received_length[14:8]};
            `RTLSB_ADDR_LEN_LOW: next_rdata = received_length[7:0];
            `RTLSB_ADDR_CHECK3: next_rdata = rx_check[31:24];
            `RTLSB_ADDR_CHECK2: next_rdata = rx_check[23:16];
            `RTLSB_ADDR_CHECK1: next_rdata = rx_check[15:8];
            `RTLSB_ADDR_CHECK0: next_rdata = rx_check[7:0];
            `RTLSB_ADDR_SRC_ADDR: next_rdata = rx_src;
            `RTLSB_ADDR_DST_ADDR: next_rdata = rx_dst;
            `RTLSB_ADDR_RUN_RSSI: next_rdata = running_signal_strength;
            `RTLSB_ADDR_PART_ID: next_rdata = PART_ID;
            `RTLSB_ADDR_VERSION_ID: next_rdata = VERSION_ID;
            `RTLSB_ADDR_IRQ3: next_rdata = irq_vector[31:24];
            `RTLSB_ADDR_IRQ2: next_rdata = irq_vector[23:16];
            `RTLSB_ADDR_IRQ1: next_rdata = irq_vector[15:8];
            `RTLSB_ADDR_IRQ0: next_rdata = irq_vector[7:0];
            default: next_rdata = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------------
    // Writes are ignored: reg_wdata_i touches no storage, and reg_wr_i only cancels a read in the same cycle.
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i && !reg_wr_i;
            if (reg_rd_i && !reg_wr_i) begin
                reg_rdata_o <= next_rdata;
            end
        end
    end

endmodule // rtlsb_status_bank

// ==== tb/rtlsb_status_bank_monitor.sv ====
// Checker of the status bank read port and of its captured fields.
`timescale 1ns/1ps
module rtlsb_status_bank_monitor (
    // Clock, reset and register port.
    input wire clock_i,
    input wire rst_n_i,
    input wire [7:0] reg_addr_i,
    input wire reg_rd_i,
    input wire reg_wr_i,
    input wire [7:0] reg_rdata_o,
    input wire reg_rvalid_o,
    // Watched sources.
    input wire rx_sync_done_i,
    input wire [7:0] signal_strength_i,
    input wire [7:0] transmit_queue_count_i,
    input wire [31:0] irq_vector_i
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // A read counts only with the write strobe low.
    wire rd_ok = reg_rd_i && !reg_wr_i;
    wire [7:0] irq_top = irq_vector_i[31:24];
    rvalid_follows_a: assert property (rd_ok |=> reg_rvalid_o)
        else $error("read not answered");
    write_silent_a: assert property (!rd_ok |=> !reg_rvalid_o && $stable(reg_rdata_o))
        else $error("answer without read");
    vco_reserved_a: assert property (rd_ok && reg_addr_i == 8'h9a |=> !reg_rdata_o[7])
        else $error("calibration bit 7 set");
    tx_info_top_a: assert property (rd_ok && reg_addr_i == 8'h9c |=> reg_rdata_o[7:6] == 2'b00)
        else $error("transmit info top bits set");
    rx_info_top_a: assert property (rd_ok && reg_addr_i == 8'h9d |=> reg_rdata_o[7:3] == 5'h00)
        else $error("receive info top bits set");
    len_high_top_a: assert property (rd_ok && reg_addr_i == 8'ha4 |=> !reg_rdata_o[7])
        else $error("length high bit 7 set");
    // The mirror is only valid once an edge has passed out of reset.
    queue_mirror_a: assert property (rd_ok && reg_addr_i == 8'h8f && $past(rst_n_i)
        |=> reg_rdata_o == $past(transmit_queue_count_i, 2))
        else $error("queue count wrong");
    irq_order_a: assert property (rd_ok && reg_addr_i == 8'hfa && $past(rst_n_i)
        |=> reg_rdata_o == $past(irq_top, 2))
        else $error("interrupt top byte wrong");
    rssi_capture_a: assert property (rx_sync_done_i ##1 (rd_ok && reg_addr_i == 8'ha2
        && !rx_sync_done_i) |=> reg_rdata_o == $past(signal_strength_i, 2))
        else $error("captured strength wrong");
    cover property (rd_ok && reg_addr_i == 8'ha2);
    cover property (reg_wr_i);
    cover property (rd_ok && reg_addr_i == 8'hfa);
endmodule // rtlsb_status_bank_monitor

bind rtlsb_status_bank rtlsb_status_bank_monitor mon_u (.*);

// ==== tb/rtlsb_host_model.sv ====
// Host model issuing register reads and writes on the bank's port.
`timescale 1ns/1ps
module rtlsb_host_model (
    // Clock and answer from the bank.
    input wire clock_i,
    input wire [7:0] reg_rdata_o,
    input wire reg_rvalid_o,
    // Request lines towards the bank.
    output reg [7:0] reg_addr_i,
    output reg reg_rd_i,
    output reg reg_wr_i,
    output reg [7:0] reg_wdata_i
);
    initial {reg_addr_i, reg_rd_i, reg_wr_i, reg_wdata_i} = 18'h00000;
    // On release the read address and the write data show the inverse, so a stale value is never mistaken for data.
    task rd(input [7:0] a, output [7:0] d, output v);
        begin
            @(posedge clock_i);
            #1 reg_addr_i = a;
            reg_rd_i = 1'b1;
            @(posedge clock_i);
            #1 reg_rd_i = 1'b0;
            reg_addr_i = ~a;
            d = reg_rdata_o;
            v = reg_rvalid_o;
        end
    endtask
    task wr(input [7:0] a, input [7:0] w);
        begin
            @(posedge clock_i);
            #1 reg_addr_i = a;
            reg_wdata_i = w;
            reg_wr_i = 1'b1;
            @(posedge clock_i);
            #1 reg_wr_i = 1'b0;
            reg_wdata_i = ~w;
        end
    endtask
endmodule // rtlsb_host_model

// ==== tb/tb_rx_tx_link_status_bank.sv ====
// Self-checking bench of the link status bank.
`timescale 1ns/1ps
module tb_rx_tx_link_status_bank;
    localparam [7:0] P_ID = 8'h3c; // Arbitrary value.
    localparam [7:0] V_ID = 8'hc3; // Arbitrary value.
    reg clock_i, rst_n_i, vco_cal_done_i, tx_start_i, tx_retx_i, rx_sync_done_i;
    reg rx_pkt_done_i, received_no_ack_flag_i, carrier_sense_i, v;
    reg [1:0] transmit_sequence_number_i, received_sequence_number_i;
    reg [7:0] transmit_queue_count_i, preamble_quality_index_i, signal_strength_i, d, last_a;
    reg [7:0] received_source_address_i, received_destination_address_i;
    reg [7:0] freq_offset_correction_i;
    reg [6:0] sync_quality_index_i;
    reg [14:0] received_length_i;
    reg [31:0] received_check_i, irq_vector_i;
    reg [126:0] vco_cal_thermo_i;
    wire [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
    wire reg_rd_i, reg_wr_i, reg_rvalid_o;
    integer n_errors, compares, i;
    rtlsb_status_bank #(.PART_ID(P_ID), .VERSION_ID(V_ID)) dut_u (.*);
    rtlsb_host_model host_u (.*);
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end
    task chk(input string nm, input [7:0] e, input [7:0] g);
        begin
            compares = compares + 1;
            if (g !== e) begin
                n_errors = n_errors + 1;
                $display("mismatch %0s at %h expected %h seen %h", nm, last_a, e, g);
            end
        end
    endtask
    task rc(input [7:0] a, input [7:0] e);
        begin
            last_a = a;
            host_u.rd(a, d, v);
            chk("rvalid", 8'h01, {7'h00, v});
            chk("rdata", e, d);
        end
    endtask
    function [7:0] rst_val(input [7:0] a);
        case (a)
            8'hfb: rst_val = 8'h09;
            8'hfc: rst_val = 8'h05;
            8'hf0: rst_val = P_ID;
            8'hf1: rst_val = V_ID;
            default: rst_val = 8'h00;
        endcase
    endfunction
    task close_out;
        begin
            $display("compares %0d n_errors %0d", compares, n_errors);
            if (n_errors == 0 && compares > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    // About 1100 cycles are needed; the 5000-cycle limit, over four times that, is a hang.
    initial begin
        #20000;
        n_errors = n_errors + 1;
        close_out;
    end
    initial begin
        {rst_n_i, vco_cal_done_i, tx_start_i, tx_retx_i, rx_sync_done_i, rx_pkt_done_i} = 6'h00;
        {received_no_ack_flag_i, carrier_sense_i, transmit_sequence_number_i} = 4'h0;
        {received_sequence_number_i, transmit_queue_count_i, preamble_quality_index_i} = 18'h0;
        {signal_strength_i, received_source_address_i, received_destination_address_i} = 24'h0;
        {freq_offset_correction_i, sync_quality_index_i, received_length_i} = 30'h0;
        {received_check_i, vco_cal_thermo_i} = 159'h0;
        irq_vector_i = 32'h0009_0500;
        n_errors = 0;
        compares = 0;
        repeat (12) @(posedge clock_i);
        #1 rst_n_i = 1'b1;
        for (i = 0; i < 256; i = i + 1) rc(i[7:0], rst_val(i[7:0]));
        $display("test reset values done");
        {signal_strength_i, preamble_quality_index_i, sync_quality_index_i} = 23'h4dc755;
        {carrier_sense_i, received_no_ack_flag_i, received_sequence_number_i} = 4'hf;
        {received_length_i, received_check_i} = 47'h5a3c_d1c2b3a4;
        {received_source_address_i, received_destination_address_i} = 16'h1234;
        {freq_offset_correction_i, transmit_queue_count_i} = 16'he780;
        {irq_vector_i, transmit_sequence_number_i} = {32'h8142_2418, 2'b10};
        vco_cal_thermo_i = {127{1'b1}} >> 27;
        {rx_sync_done_i, rx_pkt_done_i, tx_start_i, vco_cal_done_i} = 4'hf;
        @(posedge clock_i);
        #1 {rx_sync_done_i, rx_pkt_done_i, tx_start_i, vco_cal_done_i} = 4'h0;
        tx_retx_i = 1'b1;
        repeat (20) @(posedge clock_i);
        #1 tx_retx_i = 1'b0;
        signal_strength_i = 8'h3e;
        rc(8'ha2, 8'h9b);
        rc(8'hef, 8'h3e);
        signal_strength_i = 8'h40;
        rc(8'hef, 8'h40);
        rc(8'h9f, 8'h8e);
        rc(8'ha0, 8'hd5);
        rc(8'h9d, 8'h07);
        rc(8'ha4, 8'h5a);
        rc(8'ha5, 8'h3c);
        rc(8'haa, 8'h12);
        rc(8'hab, 8'h34);
        rc(8'h9a, 8'h64);
        rc(8'h9c, 8'h2f);
        rc(8'h8f, 8'h80);
        rc(8'h9e, 8'he7);
        for (i = 0; i < 4; i = i + 1) rc(i[7:0] + 8'ha6, received_check_i[31-8*i -: 8]);
        for (i = 0; i < 4; i = i + 1) rc(i[7:0] + 8'hfa, irq_vector_i[31-8*i -: 8]);
        $display("test captures done");
        for (i = 0; i < 256; i = i + 1) host_u.wr(i[7:0], 8'hff);
        rc(8'ha2, 8'h9b);
        rc(8'h9c, 8'h2f);
        rc(8'hf0, P_ID);
        // New packet with a retry at its start edge, then two more retries.
        {tx_start_i, tx_retx_i, transmit_sequence_number_i} = 4'hd;
        @(posedge clock_i);
        #1 tx_start_i = 1'b0;
        repeat (2) @(posedge clock_i);
        #1 tx_retx_i = 1'b0;
        rc(8'h9c, 8'h13);
        // Sync detection one edge before the read that fetches the capture.
        signal_strength_i = 8'h66;
        rx_sync_done_i = 1'b1;
        fork
            rc(8'ha2, 8'h66);
            begin
                @(posedge clock_i);
                #1 rx_sync_done_i = 1'b0;
            end
        join
        vco_cal_thermo_i = {127{1'b1}};
        vco_cal_done_i = 1'b1;
        @(posedge clock_i);
        #1 vco_cal_done_i = 1'b0;
        rc(8'h9a, 8'h7f);
        $display("test writes and full calibration done");
        close_out;
    end
endmodule // tb_rx_tx_link_status_bank
